// file: logic/fut_flash_front.sv
// register front of the program flash controller: unlock key and target address
//
// Added by the designer: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "fut_defs.svh"
module fut_flash_front #(
	parameter logic [31:0] KEY1 = `FUT_KEY1_DEF,
	parameter logic [31:0] KEY2 = `FUT_KEY2_DEF
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic flash_op_valid,
	output logic [1:0] flash_op_kind,
	output logic [31:0] flash_op_addr,
	output logic flash_op_all
);
	////////////////////////////////////////////////////////////
	// bus address phase capture
	logic wr_pend_q;
	logic rd_pend_q;
	logic [11:0] addr_q;
	wire take = hsel && hready && htrans[1];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q <= 12'h000;
		end else begin
			wr_pend_q <= take && hwrite;
			rd_pend_q <= take && !hwrite;
			addr_q <= take ? haddr[11:0] : addr_q;
		end
	end
	// zero wait states, response always okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	wire wr_ctrl = wr_pend_q && addr_q == `FUT_OFF_CTRL;
	wire wr_key = wr_pend_q && addr_q == `FUT_OFF_KEY;
	wire wr_addr = wr_pend_q && addr_q == `FUT_OFF_ADDR;

	////////////////////////////////////////////////////////////
	// registers and unlock sequencer
	logic [31:0] tgt_addr_q;
	logic [1:0] op_q;
	logic busy_q;
	logic [7:0] cnt_q;
	logic done_q;
	fut_pkg::fut_unl_type unl_q;
	fut_pkg::fut_unl_type unl_d;
	wire start = wr_ctrl && hwdata[`FUT_CTRL_START];
	wire go = start && unl_q == fut_pkg::FUT_UNL_OPEN && !busy_q;
	// a control or address register write breaks the unlock sequence
	wire relock = wr_ctrl || wr_addr;
	wire key1_hit = wr_key && hwdata == KEY1;
	wire key2_hit = wr_key && hwdata == KEY2;
	// op named by the start write itself, so kind, address and bulk flag agree
	fut_pkg::fut_op_type start_op;
	assign start_op = fut_pkg::fut_op_type'(hwdata[`FUT_CTRL_OP_MSB:`FUT_CTRL_OP_LSB]);
	always_comb begin
		unl_d = unl_q;
		if (relock) begin
			unl_d = fut_pkg::FUT_UNL_IDLE;
		end else if (wr_key) begin
			unique case (unl_q)
				fut_pkg::FUT_UNL_IDLE,
				fut_pkg::FUT_UNL_OPEN: begin
					unl_d = key1_hit ? fut_pkg::FUT_UNL_KEY1 : fut_pkg::FUT_UNL_IDLE;
				end
				fut_pkg::FUT_UNL_KEY1: begin
					if (key2_hit)
						unl_d = fut_pkg::FUT_UNL_OPEN;
					else if (key1_hit)
						unl_d = fut_pkg::FUT_UNL_KEY1;
					else
						unl_d = fut_pkg::FUT_UNL_IDLE;
				end
				default: unl_d = fut_pkg::FUT_UNL_IDLE;
			endcase
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			unl_q <= fut_pkg::FUT_UNL_IDLE;
			tgt_addr_q <= `FUT_RESET_WORD;
			op_q <= 2'h0;
			busy_q <= 1'b0;
			cnt_q <= 8'h00;
			done_q <= 1'b0;
		end else begin
			unl_q <= unl_d;
			if (wr_addr && !busy_q)
				tgt_addr_q <= hwdata;
			if (wr_ctrl && !busy_q)
				op_q <= hwdata[`FUT_CTRL_OP_MSB:`FUT_CTRL_OP_LSB];
			busy_q <= go || (busy_q && cnt_q != 8'h01);
			cnt_q <= go ? `FUT_OP_CYCLES : (busy_q ? cnt_q - 8'h01 : cnt_q);
			done_q <= (busy_q && cnt_q == 8'h01) || (done_q && !go);
		end
	end

	////////////////////////////////////////////////////////////
	// operation address selection
	function automatic logic [31:0] align_down(input logic [31:0] a, input int lsb);
		align_down = (a >> lsb) << lsb;
	endfunction
	wire [31:0] sel_addr = (start_op == fut_pkg::FUT_OP_BULK) ? `FUT_RESET_WORD :
		(start_op == fut_pkg::FUT_OP_PAGE) ? align_down(tgt_addr_q, `FUT_PAGE_LSB) :
		(start_op == fut_pkg::FUT_OP_ROW) ? align_down(tgt_addr_q, `FUT_ROW_LSB) :
		align_down(tgt_addr_q, `FUT_WORD_LSB);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flash_op_valid <= 1'b0;
			flash_op_kind <= 2'h0;
			flash_op_addr <= `FUT_RESET_WORD;
			flash_op_all <= 1'b0;
		end else begin
			flash_op_valid <= go;
			flash_op_kind <= go ? start_op : flash_op_kind;
			flash_op_addr <= go ? sel_addr : flash_op_addr;
			flash_op_all <= go ? (start_op == fut_pkg::FUT_OP_BULK) : flash_op_all;
		end
	end

	////////////////////////////////////////////////////////////
	// read data
	wire [31:0] stat_word = {29'h0, done_q, busy_q, unl_q == fut_pkg::FUT_UNL_OPEN};
	wire [31:0] ctrl_word = {16'h0, busy_q, 13'h0, op_q};
	// a read right behind an address write returns the new address
	wire [31:0] tgt_addr_rd = (wr_addr && !busy_q) ? hwdata : tgt_addr_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= `FUT_RESET_WORD;
		else if (take && !hwrite) begin
			unique case (haddr[11:0])
				`FUT_OFF_CTRL: hrdata <= ctrl_word;
				`FUT_OFF_ADDR: hrdata <= tgt_addr_rd;
				`FUT_OFF_STAT: hrdata <= stat_word;
				default: hrdata <= `FUT_RESET_WORD;
			endcase
		end
	end

	////////////////////////////////////////////////////////////
	// checks
	a_key_reads_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_pend_q && addr_q == `FUT_OFF_KEY |-> hrdata == 32'h0)
		else $error("key register read nonzero");
	sequence s_unlocked;
		unl_q == fut_pkg::FUT_UNL_OPEN;
	endsequence
	a_op_needs_unlock: assert property (@(posedge hclk) disable iff (!hresetn)
		flash_op_valid |-> $past(unl_q) == fut_pkg::FUT_UNL_OPEN)
		else $error("flash op without unlock");
	a_start_fires: assert property (@(posedge hclk) disable iff (!hresetn)
		s_unlocked ##0 (start && !busy_q) |=> flash_op_valid ##1 !flash_op_valid)
		else $error("unlocked start did not fire once");
	a_addr_write: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_addr && !busy_q |=> tgt_addr_q == $past(hwdata))
		else $error("target address not stored");
	a_bulk_ignores: assert property (@(posedge hclk) disable iff (!hresetn)
		flash_op_valid && flash_op_all |-> flash_op_addr == 32'h0)
		else $error("bulk erase used address");
	a_page_sel: assert property (@(posedge hclk) disable iff (!hresetn)
		go && start_op == fut_pkg::FUT_OP_PAGE |=> flash_op_addr == {$past(tgt_addr_q[31:10]), 10'h0})
		else $error("page address wrong");
	a_row_sel: assert property (@(posedge hclk) disable iff (!hresetn)
		go && start_op == fut_pkg::FUT_OP_ROW |=> flash_op_addr == {$past(tgt_addr_q[31:7]), 7'h0})
		else $error("row address wrong");
	a_word_sel: assert property (@(posedge hclk) disable iff (!hresetn)
		go && start_op == fut_pkg::FUT_OP_WORD |=> flash_op_addr == {$past(tgt_addr_q[31:2]), 2'h0})
		else $error("word address wrong");
	// unlock sequence steps, launch pulse and target address register
	sequence s_first_key;
		key1_hit && !(key2_hit && unl_q == fut_pkg::FUT_UNL_KEY1);
	endsequence
	sequence s_second_key;
		key2_hit && unl_q == fut_pkg::FUT_UNL_KEY1;
	endsequence
	a_first_key_arms: assert property (@(posedge hclk) disable iff (!hresetn)
		s_first_key |=> unl_q == fut_pkg::FUT_UNL_KEY1)
		else $error("first key did not arm the lock");
	a_second_key_opens: assert property (@(posedge hclk) disable iff (!hresetn)
		s_second_key |=> s_unlocked)
		else $error("second key did not open the lock");
	a_wrong_key_locks: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_key && !key1_hit && !key2_hit |=> unl_q == fut_pkg::FUT_UNL_IDLE)
		else $error("wrong key left the lock armed");
	a_write_relocks: assert property (@(posedge hclk) disable iff (!hresetn)
		relock |=> unl_q == fut_pkg::FUT_UNL_IDLE)
		else $error("register write did not relock");
	a_locked_no_op: assert property (@(posedge hclk) disable iff (!hresetn)
		start && unl_q != fut_pkg::FUT_UNL_OPEN |=> !flash_op_valid)
		else $error("locked start launched an operation");
	a_pulse_single: assert property (@(posedge hclk) disable iff (!hresetn)
		flash_op_valid |=> !flash_op_valid)
		else $error("launch pulse longer than one cycle");
	a_addr_held_busy: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_addr && busy_q |=> $stable(tgt_addr_q))
		else $error("target address changed while busy");
	a_key_keeps_addr: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_key |=> $stable(tgt_addr_q))
		else $error("key write disturbed target address");
	a_reset_clears: assert property (@(posedge hclk)
		$rose(hresetn) |-> tgt_addr_q == `FUT_RESET_WORD)
		else $error("target address not zero after reset");
	// launch outputs
	a_kind_all_agree: assert property (@(posedge hclk) disable iff (!hresetn)
		flash_op_valid |-> flash_op_all == (flash_op_kind == fut_pkg::FUT_OP_BULK))
		else $error("bulk flag and kind disagree");
	a_bulk_sel: assert property (@(posedge hclk) disable iff (!hresetn)
		go && start_op == fut_pkg::FUT_OP_BULK |=> flash_op_all && flash_op_addr == `FUT_RESET_WORD)
		else $error("bulk launch not flagged");
	a_op_outputs_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		!go |=> $stable(flash_op_addr) && $stable(flash_op_kind) && $stable(flash_op_all))
		else $error("launch outputs changed without a launch");
endmodule

// file: logic/fut_defs.svh
// constants for the flash unlock and target address block
// Contract
// - unlock key register is write-only, 32 bits, always reads zero.
// - key writes form unlock sequence; flash untouched unless sequence completed.
// - target address register is 32-bit read/write, zero after reset.
// - whole-array erase ignores the target address entirely.
// - page erase erases only the page the target address selects.
// - row program writes the row the target address selects.
// - word program writes the single word the target address selects.
`ifndef FUT_DEFS_SVH
`define FUT_DEFS_SVH
`define FUT_OFF_CTRL 12'h000
`define FUT_OFF_KEY 12'h004
`define FUT_OFF_ADDR 12'h008
`define FUT_OFF_STAT 12'h00c
// arbitrary default keys; a product sets its own pair
`define FUT_KEY1_DEF 32'h11111111
`define FUT_KEY2_DEF 32'h22222222
`define FUT_CTRL_OP_LSB 0
`define FUT_CTRL_OP_MSB 1
`define FUT_CTRL_START 15
`define FUT_RESET_WORD 32'h00000000
`define FUT_PAGE_LSB 10
`define FUT_ROW_LSB 7
`define FUT_WORD_LSB 2
`define FUT_OP_CYCLES 8'h10
`endif

// file: logic/fut_pkg.sv
// types for the flash unlock and target address block
package fut_pkg;
	typedef enum logic [1:0] {
		FUT_OP_WORD,
		FUT_OP_ROW,
		FUT_OP_PAGE,
		FUT_OP_BULK
	} fut_op_type;
	typedef enum logic [1:0] {
		FUT_UNL_IDLE,
		FUT_UNL_KEY1,
		FUT_UNL_OPEN
	} fut_unl_type;
endpackage

// file: test/test_flash_unlock_and_target_address.sv
// bench for the flash unlock and target address front
`timescale 1ns/1ps
`include "fut_defs.svh"
module test_flash_unlock_and_target_address;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, op_v, op_all;
	logic [1:0] htrans, op_k;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, op_a, r, a;
	int n_errors, comparisons;
	fut_flash_front dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .flash_op_valid(op_v), .flash_op_kind(op_k),
		.flash_op_addr(op_a), .flash_op_all(op_all));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
			n_errors++;
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] off, input logic [31:0] d);
		@(posedge hclk);
		haddr <= {20'h00000, off};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic final_report();
		$display("mismatches %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	initial begin
		repeat (3000) @(posedge hclk);
		n_errors++;
		final_report();
	end
	initial begin
		hresetn = 1'b0;
		hsel = 1'b1;
		hwrite = 1'b0;
		htrans = 2'h0;
		hsize = 3'h2;
		haddr = 32'h00000000;
		hwdata = 32'h00000000;
		n_errors = 0;
		comparisons = 0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, `FUT_OFF_ADDR, 32'h00000000);
		chk(r, 32'h00000000);
		bus(1'b1, `FUT_OFF_KEY, 32'h5a5aa5a5);
		bus(1'b0, `FUT_OFF_KEY, 32'h00000000);
		chk(r, 32'h00000000);
		chk({31'h0, hresp}, 32'h00000000);
		bus(1'b1, `FUT_OFF_ADDR, 32'hfedc_ba98);
		bus(1'b0, `FUT_OFF_ADDR, 32'h00000000);
		chk(r, 32'hfedcba98);
		bus(1'b0, 12'h010, 32'h00000000);
		chk(r, 32'h00000000);
		// start with no keys, then with a wrong second key
		bus(1'b1, `FUT_OFF_CTRL, 32'h00008002);
		#1 chk({31'h0, op_v}, 32'h00000000);
		bus(1'b1, `FUT_OFF_KEY, `FUT_KEY1_DEF);
		bus(1'b1, `FUT_OFF_KEY, 32'h12345678);
		bus(1'b1, `FUT_OFF_CTRL, 32'h00008002);
		#1 chk({31'h0, op_v}, 32'h00000000);
		a = 32'h1234_5ab7;
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, `FUT_OFF_ADDR, a);
			bus(1'b1, `FUT_OFF_CTRL, {30'h0, k[1:0]});
			bus(1'b1, `FUT_OFF_KEY, `FUT_KEY1_DEF);
			bus(1'b1, `FUT_OFF_KEY, `FUT_KEY2_DEF);
			bus(1'b1, `FUT_OFF_CTRL, 32'h00008000 | k);
			#1 chk({31'h0, op_v}, 32'h00000001);
			chk({30'h0, op_k}, k);
			chk(op_a, k == 3 ? 32'h0 : k == 2 ? a & ~32'h3ff : k == 1 ? a & ~32'h7f : a & ~32'h3);
			chk({31'h0, op_all}, {31'h0, k == 3});
			@(posedge hclk);
			#1 chk({31'h0, op_v}, 32'h00000000);
			bus(1'b1, `FUT_OFF_ADDR, ~a);
			bus(1'b0, `FUT_OFF_ADDR, 32'h00000000);
			chk(r, a);
			repeat (20) @(posedge hclk);
			bus(1'b1, `FUT_OFF_CTRL, 32'h00008000 | k);
			#1 chk({31'h0, op_v}, 32'h00000000);
		end
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, `FUT_OFF_ADDR, 32'h00000000);
		chk(r, `FUT_RESET_WORD);
		final_report();
	end
endmodule
